// [rtl/clock_buffer_status_id_regs.sv]
// Serial-bus slave holding pin status, identifiers and read byte count
`timescale 1ns/1ps
`include "clkbuf_regs_params.svh"
`default_nettype none
module clock_buffer_status_id_regs
   import clkbuf_regs_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = 7'h6A,  // Arbitrary value
   parameter logic [3:0] REVISION   = 4'h2,   // Arbitrary value
   parameter logic [3:0] VENDOR     = 4'h5,   // Arbitrary value
   parameter logic [7:0] DEVICE_ID  = 8'h3C   // Arbitrary value
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        en,
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic [12:5] out_enable_n,
   output logic      [4:0]  read_count
);

   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic [1:0]    bus_s;
   logic [12:5]   pins_s;
   logic          scl_d_r;
   logic          sda_d_r;
   logic          scl_rise;
   logic          scl_fall;
   logic          start_det;
   logic          stop_det;
   logic          active;
   bus_state_type state_r;
   logic [3:0]    bit_cnt_r;
   logic [7:0]    shift_r;
   logic [7:0]    idx_r;
   logic [4:0]    count_r;
   logic [4:0]    count_nxt;
   logic [7:0]    rd_data;
   logic          addr_hit;
   logic          ack_fall;
   logic          wr_evt;
   logic          reg_load;
   logic          host_nack;
   logic          host_slot;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   pin_sync #(
      .WIDTH (2),
      .INIT  (2'h3)
   ) u_bus_sync (
      .mclk     (mclk),
      .nrst     (nrst),
      .en       (en),
      .async_in ({scl_in, sda_in}),
      .sync_out (bus_s)
   );

   pin_sync #(
      .WIDTH (8),
      .INIT  (8'hFF)
   ) u_pin_sync (
      .mclk     (mclk),
      .nrst     (nrst),
      .en       (en),
      .async_in (out_enable_n),
      .sync_out (pins_s)
   );

   // ----------------------------------------------------------------
   // Bus edge and condition detection
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else if (en) begin
         scl_d_r <= bus_s[1];
         sda_d_r <= bus_s[0];
      end
   end

   assign scl_rise  = en & bus_s[1] & ~scl_d_r;
   assign scl_fall  = en & ~bus_s[1] & scl_d_r;
   assign start_det = en & bus_s[1] & scl_d_r & sda_d_r & ~bus_s[0];
   assign stop_det  = en & bus_s[1] & scl_d_r & ~sda_d_r & bus_s[0];
   assign active    = ~start_det & ~stop_det & (state_r != st_idle);

   // ----------------------------------------------------------------
   // Byte events
   // ----------------------------------------------------------------
   assign addr_hit  = (shift_r[7:1] == SLAVE_ADDR);
   assign ack_fall  = active & scl_fall & (bit_cnt_r == `BIT_ACK);
   assign wr_evt    = ack_fall & (state_r == st_wdata);
   // Host answer slot only, not the address ack
   assign host_slot = active & scl_rise & (state_r == st_read)
                    & (bit_cnt_r == `BIT_ACK) & ~sda_oe;
   assign host_nack = host_slot & bus_s[0];
   assign reg_load  = host_slot & ~bus_s[0];
   assign count_nxt = shift_r[`CNT_MSB:`CNT_LSB];

   reg_read_mux u_mux (
      .idx        (idx_r),
      .pin_status (pins_s),
      .count      (count_r),
      .revision   (REVISION),
      .vendor     (VENDOR),
      .device     (DEVICE_ID),
      .rd_data    (rd_data)
   );

   // ----------------------------------------------------------------
   // Transfer state machine
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r   <= st_idle;
         bit_cnt_r <= 4'h0;
         shift_r   <= 8'h00;
         idx_r     <= 8'h00;
         sda_oe    <= 1'b0;
      end else if (start_det) begin
         state_r   <= st_addr;
         bit_cnt_r <= 4'h0;
         sda_oe    <= 1'b0;
      end else if (stop_det) begin
         state_r   <= st_idle;
         bit_cnt_r <= 4'h0;
         sda_oe    <= 1'b0;
      end else if (active && scl_rise) begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         if (state_r != st_read && bit_cnt_r < `BIT_ACK) begin
            shift_r <= {shift_r[6:0], bus_s[0]};
         end
         // Next register byte after host ack
         if (reg_load) begin
            shift_r <= rd_data;
            idx_r   <= idx_r + 8'h01;
         end
         if (host_nack) begin
            state_r <= st_idle;
         end
      end else if (active && scl_fall) begin
         if (bit_cnt_r == `BIT_ACK) begin
            case (state_r)
               st_addr: begin
                  if (addr_hit) begin
                     sda_oe <= 1'b1;
                     if (shift_r[0]) begin
                        state_r <= st_read;
                        shift_r <= {3'h0, count_r};
                     end else begin
                        state_r <= st_cmd;
                     end
                  end else begin
                     state_r <= st_idle;
                  end
               end
               st_cmd: begin
                  sda_oe  <= 1'b1;
                  idx_r   <= shift_r;
                  state_r <= st_wcnt;
               end
               st_wcnt: begin
                  sda_oe  <= 1'b1;
                  state_r <= st_wdata;
               end
               st_wdata: begin
                  sda_oe <= 1'b1;
                  idx_r  <= idx_r + 8'h01;
               end
               st_read: begin
                  sda_oe <= 1'b0;
               end
               default: begin
                  state_r <= st_idle;
               end
            endcase
         end else if (bit_cnt_r == `BIT_END) begin
            bit_cnt_r <= 4'h0;
            sda_oe    <= (state_r == st_read) ? ~shift_r[7] : 1'b0;
         end else if (state_r == st_read) begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe  <= ~shift_r[6];
         end
      end
   end

   assign sda_out = 1'b0;

   // ----------------------------------------------------------------
   // Byte count register
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         count_r <= `CNT_RESET;
      end else if (wr_evt && idx_r == `IDX_BYTE_COUNT) begin
         count_r <= count_nxt;
      end
   end

   assign read_count = count_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Pin bit order
   pin_order_a: assert property (@(posedge mclk) disable iff (!nrst)
      reg_load && idx_r == `IDX_PIN_STATUS |=> shift_r == $past(pins_s))
      else $error("pin status byte out of order");

   pin_level_a: assert property (@(posedge mclk) disable iff (!nrst)
      reg_load && idx_r == `IDX_PIN_STATUS && !pins_s[5] |=> !shift_r[0])
      else $error("low enable pin read as one");

   status_ro_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_evt && idx_r == `IDX_PIN_STATUS |=> $stable(count_r))
      else $error("status write changed state");

   rsvd_zero_a: assert property (@(posedge mclk) disable iff (!nrst)
      reg_load && (idx_r == `IDX_RSVD_FOUR || idx_r == `IDX_RSVD_EIGHT)
      |=> shift_r == 8'h00)
      else $error("reserved byte not zero");

   rev_vendor_a: assert property (@(posedge mclk) disable iff (!nrst)
      reg_load && idx_r == `IDX_REV_VENDOR |=> shift_r == {REVISION, VENDOR})
      else $error("revision or vendor wrong");

   device_id_a: assert property (@(posedge mclk) disable iff (!nrst)
      reg_load && idx_r == `IDX_DEVICE_ID |=> shift_r == DEVICE_ID)
      else $error("device identifier wrong");

   count_field_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_evt && idx_r == `IDX_BYTE_COUNT |=> count_r == $past(count_nxt))
      else $error("count write lost");

   count_reset_a: assert property (@(posedge mclk) disable iff (!nrst)
      !$past(nrst) |-> count_r == `CNT_RESET)
      else $error("count not eight after reset");

   count_first_a: assert property (@(posedge mclk) disable iff (!nrst)
      ack_fall && state_r == st_addr && addr_hit && shift_r[0]
      |=> sda_oe && state_r == st_read && shift_r == {3'h0, $past(count_r)})
      else $error("block read did not start with count");

   ignore_wr_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_evt && idx_r != `IDX_BYTE_COUNT |=> $stable(count_r) ##1 $stable(count_r))
      else $error("write to fixed byte changed count");

   pin_msb_a: assert property (@(posedge mclk) disable iff (!nrst)
      reg_load && idx_r == `IDX_PIN_STATUS |=> shift_r[7] == $past(pins_s[12])
      && shift_r[0] == $past(pins_s[5]))
      else $error("pin twelve not in bit seven");

   // Count byte kept in address ack
   count_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
      active && scl_rise && state_r == st_read && bit_cnt_r == `BIT_ACK && sda_oe
      |=> shift_r == $past(shift_r) && idx_r == $past(idx_r))
      else $error("count byte overwritten in address ack");

   nack_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
      host_nack |=> state_r == st_idle && !sda_oe)
      else $error("device kept sending after nack");

   wr_ack_a: assert property (@(posedge mclk) disable iff (!nrst)
      wr_evt |=> sda_oe)
      else $error("data byte not acknowledged");

   // Main scenarios reached
   count_byte_c: cover property (@(posedge mclk) disable iff (!nrst)
      ack_fall && state_r == st_addr && addr_hit && shift_r[0]);
   addr_miss_c: cover property (@(posedge mclk) disable iff (!nrst)
      ack_fall && state_r == st_addr && !addr_hit);
   count_wr_c: cover property (@(posedge mclk) disable iff (!nrst)
      wr_evt && idx_r == `IDX_BYTE_COUNT);
   block_read_c: cover property (@(posedge mclk) disable iff (!nrst)
      reg_load && idx_r == `IDX_PIN_STATUS);
   read_nack_c: cover property (@(posedge mclk) disable iff (!nrst)
      host_nack);

endmodule : clock_buffer_status_id_regs
`default_nettype wire

// [inc/clkbuf_regs_params.svh]
// Register indexes, field positions, reset values and bit counts of the status and id bank
// Notes on behaviour
// - Byte 3 bits 7..0 mirror enables 12..5
// - Status bit equals live pin level
// - Status byte read-only, no stored default
// - Bytes 4 and 8 reserved only
// - Byte 5: revision high nibble, vendor low
// - Byte 6: fixed eight-bit device identifier
// - Byte 7 bits 4..0 count, 7..5 reserved
// - Count is sent as the first block read byte but does not limit its length, resets to 8
// - Block read sends count, then bytes from index
`ifndef CLKBUF_REGS_PARAMS_SVH
`define CLKBUF_REGS_PARAMS_SVH

`define IDX_PIN_STATUS  8'h03
`define IDX_RSVD_FOUR   8'h04
`define IDX_REV_VENDOR  8'h05
`define IDX_DEVICE_ID   8'h06
`define IDX_BYTE_COUNT  8'h07
`define IDX_RSVD_EIGHT  8'h08

`define REV_MSB         7
`define REV_LSB         4
`define VEN_MSB         3
`define VEN_LSB         0
`define CNT_MSB         4
`define CNT_LSB         0
`define CNT_RESET       5'h08

`define BIT_ACK         4'h8
`define BIT_END         4'h9

`endif

// [inc/clkbuf_regs_pkg.sv]
// Types shared by the status and id register bank
package clkbuf_regs_pkg;

   typedef enum logic [2:0] {
      st_idle,
      st_addr,
      st_cmd,
      st_wcnt,
      st_wdata,
      st_read
   } bus_state_type;

endpackage : clkbuf_regs_pkg

// [rtl/pin_sync.sv]
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int               WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT  = '0
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             en,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_r   <= INIT;
         sync_out <= INIT;
      end else if (en) begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end

endmodule : pin_sync
`default_nettype wire

// [rtl/reg_read_mux.sv]
// Read data selection for register bytes 3 to 8
`timescale 1ns/1ps
`include "clkbuf_regs_params.svh"
`default_nettype none
module reg_read_mux (
   input  wire logic [7:0] idx,
   input  wire logic [7:0] pin_status,
   input  wire logic [4:0] count,
   input  wire logic [3:0] revision,
   input  wire logic [3:0] vendor,
   input  wire logic [7:0] device,
   output logic      [7:0] rd_data
);

   always_comb begin
      rd_data = 8'h00;
      case (idx)
         `IDX_PIN_STATUS: rd_data = pin_status;
         `IDX_REV_VENDOR: begin
            rd_data[`REV_MSB:`REV_LSB] = revision;
            rd_data[`VEN_MSB:`VEN_LSB] = vendor;
         end
         `IDX_DEVICE_ID: rd_data = device;
         `IDX_BYTE_COUNT: rd_data[`CNT_MSB:`CNT_LSB] = count;
         default: rd_data = 8'h00;
      endcase
   end

endmodule : reg_read_mux
`default_nettype wire

// [dv/smbus_host_model.sv]
// Behavioural serial-bus host that drives the clock and data pins
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model #(
   parameter int Q = 5
) (
   input  wire logic mclk,
   input  wire logic sda_out,
   input  wire logic sda_oe,
   output logic      scl,
   output logic      sda_line
);
   logic sda_host;
   // Open-drain data wire with pull-up
   assign sda_line = sda_host & ~(sda_oe & ~sda_out);
   initial begin
      scl      = 1'b1;
      sda_host = 1'b1;
   end
   task automatic gap();
      repeat (Q) @(posedge mclk);
      #2;
   endtask : gap
   task automatic start();
      sda_host = 1'b1;
      gap();
      scl = 1'b1;
      gap();
      sda_host = 1'b0;
      gap();
      scl = 1'b0;
      gap();
   endtask : start
   task automatic stop();
      sda_host = 1'b0;
      gap();
      scl = 1'b1;
      gap();
      sda_host = 1'b1;
      gap();
   endtask : stop
   task automatic bit_io(input logic b, output logic r);
      sda_host = b;
      gap();
      scl = 1'b1;
      gap();
      r = sda_line;
      gap();
      scl = 1'b0;
      gap();
   endtask : bit_io
   task automatic wr_byte(input logic [7:0] b, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, ack_n);
   endtask : wr_byte
   // Ack each byte, nack the last
   task automatic rd_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, r);
   endtask : rd_byte
endmodule : smbus_host_model
`default_nettype wire

// [dv/clock_buffer_status_id_regs_test.sv]
// Self-checking bench for the status and id register bank
`timescale 1ns/1ps
`include "clkbuf_regs_params.svh"
`default_nettype none
module clock_buffer_status_id_regs_test;
   // Arbitrary values
   localparam logic [6:0] ADDR = 7'h51;
   localparam logic [3:0] REV  = 4'h9;
   localparam logic [3:0] VEN  = 4'h6;
   localparam logic [7:0] DEV  = 8'hA7;
   logic        mclk = 1'b0;
   logic        nrst = 1'b0;
   logic        en   = 1'b1;
   logic [12:5] pins = 8'h00;
   logic        scl;
   logic        sda_line;
   logic        sda_out;
   logic        sda_oe;
   logic [4:0]  read_count;
   logic [7:0]  rdat [0:9];
   int          error_cnt   = 0;
   int          checks_done = 0;
   always #10 mclk = ~mclk;
   clock_buffer_status_id_regs #(.SLAVE_ADDR(ADDR), .REVISION(REV), .VENDOR(VEN),
      .DEVICE_ID(DEV)) dut (.mclk(mclk), .nrst(nrst), .en(en), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .out_enable_n(pins),
      .read_count(read_count));
   smbus_host_model host (.mclk(mclk), .sda_out(sda_out), .sda_oe(sda_oe), .scl(scl),
      .sda_line(sda_line));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic send(input logic [7:0] b, input logic exp_n);
      logic a;
      host.wr_byte(b, a);
      check("ack", {7'h00, a}, {7'h00, exp_n});
   endtask : send
   task automatic write_block(input logic [7:0] idx, input logic [7:0] d[$]);
      host.start();
      send({ADDR, 1'b0}, 1'b0);
      send(idx, 1'b0);
      send(8'(d.size()), 1'b0);
      foreach (d[i]) send(d[i], 1'b0);
      host.stop();
   endtask : write_block
   task automatic read_block(input logic [7:0] idx, input int n);
      host.start();
      send({ADDR, 1'b0}, 1'b0);
      send(idx, 1'b0);
      host.start();
      send({ADDR, 1'b1}, 1'b0);
      host.rd_byte(1'b0, rdat[0]);
      for (int i = 1; i <= n; i++) host.rd_byte(i == n, rdat[i]);
      host.stop();
   endtask : read_block
   task automatic check_bank(input logic [7:0] p, input logic [4:0] cnt);
      @(posedge mclk);
      #2 pins = p;
      read_block(`IDX_PIN_STATUS, 6);
      check("count byte", rdat[0], {3'h0, cnt});
      check("pin status", rdat[1], p);
      check("byte four", rdat[2], 8'h00);
      check("rev vendor", rdat[3], {REV, VEN});
      check("device id", rdat[4], DEV);
      check("count reg", rdat[5], {3'h0, cnt});
      check("byte eight", rdat[6], 8'h00);
      check("count port", {3'h0, read_count}, {3'h0, cnt});
   endtask : check_bank
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic reset_values();
      check("count reset", {3'h0, read_count}, {3'h0, `CNT_RESET});
      check("sda idle", {7'h00, sda_oe}, 8'h00);
      check("sda value", {7'h00, sda_out}, 8'h00);
   endtask : reset_values
   task automatic live_pins();
      check_bank(8'h1E, `CNT_RESET);
      check_bank(8'hC1, `CNT_RESET);
   endtask : live_pins
   task automatic ignored_writes();
      write_block(`IDX_PIN_STATUS, '{8'hFF, 8'hFF, 8'hFF, 8'hFF});
      write_block(`IDX_RSVD_EIGHT, '{8'hFF});
      check_bank(8'h3C, `CNT_RESET);
   endtask : ignored_writes
   task automatic count_write();
      write_block(`IDX_BYTE_COUNT, '{8'hFF});
      check_bank(8'h0F, 5'h1F);
      write_block(`IDX_BYTE_COUNT, '{8'h03});
      check_bank(8'hF0, 5'h03);
   endtask : count_write
   task automatic frozen_write();
      @(posedge mclk);
      #2 en = 1'b0;
      host.start();
      send({ADDR, 1'b0}, 1'b1);
      host.stop();
      @(posedge mclk);
      #2 en = 1'b1;
      check_bank(8'h55, 5'h03);
   endtask : frozen_write
   task automatic wrong_address();
      host.start();
      send({ADDR ^ 7'h01, 1'b0}, 1'b1);
      host.stop();
   endtask : wrong_address
   task automatic reset_midrun();
      @(posedge mclk);
      #2 nrst = 1'b0;
      repeat (5) @(posedge mclk);
      #2 nrst = 1'b1;
      repeat (3) @(posedge mclk);
      #2;
      check("count after reset", {3'h0, read_count}, {3'h0, `CNT_RESET});
      check_bank(8'h81, `CNT_RESET);
   endtask : reset_midrun
   task automatic tally_and_finish();
      $display("Checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge mclk);
      #2 nrst = 1'b1;
      repeat (3) @(posedge mclk);
      #2;
      reset_values();
      live_pins();
      ignored_writes();
      count_write();
      frozen_write();
      wrong_address();
      reset_midrun();
      tally_and_finish();
   end
   initial begin
      repeat (60000) @(posedge mclk);
      error_cnt++;
      tally_and_finish();
   end
endmodule : clock_buffer_status_id_regs_test
`default_nettype wire
